// *** design/flb_bus_edges.sv ***
// Edge and condition detector for the serial clock and data pins.
// Assumes both pins are already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module flb_bus_edges (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output var flb_pkg::flb_bus_ev_t ev
);

  logic scl_reg;
  logic sda_reg;

  // Idle bus is high, so reset to high to avoid a false edge after release
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= scl_in;
      sda_reg <= sda_in;
    end
  end

  assign ev.scl_rise = ~scl_reg & scl_in;
  assign ev.scl_fall = scl_reg & ~scl_in;
  assign ev.start = scl_reg & scl_in & sda_reg & ~sda_in;
  assign ev.stop = scl_reg & scl_in & ~sda_reg & sda_in;

endmodule // flb_bus_edges

`default_nettype wire

// *** design/flb_params.svh ***
// Constants of the flash LED register bank: offsets, fields, defaults, timing.
// Assumes inclusion by bare name from the package and the register bank module.
`ifndef FLB_PARAMS_SVH
`define FLB_PARAMS_SVH

`define FLB_I2C_ADDR 7'h33
`define FLB_PTR_W 3
`define FLB_REG_VIDEO 3'h0
`define FLB_REG_MODE 3'h1
`define FLB_REG_MODE_COPY 3'h2
`define FLB_RST_VIDEO 8'h0A
`define FLB_RST_MODE 2'h0
`define FLB_RST_FLASH2 6'h10
`define FLB_SOFT_RESET_BIT 7
`define FLB_FREE_BIT 6
`define FLB_CH13_MSB 5
`define FLB_CH13_LSB 3
`define FLB_CH2_MSB 2
`define FLB_CH2_LSB 0
`define FLB_MODE_MSB 7
`define FLB_MODE_LSB 6
`define FLB_FC2_MSB 5
`define FLB_FC2_LSB 0
`define FLB_STEP_MA 11'h019
`define FLB_BOOST_LO_CODE 3'h6
`define FLB_BOOST_HI_CODE 3'h7
`define FLB_BOOST_LO_MA 9'h0E1
`define FLB_BOOST_HI_MA 9'h145
`define FLB_CLK_KHZ 50000
`define FLB_SAFETY_MS 13000
`define FLB_SAFETY_CYCLES (`FLB_SAFETY_MS * `FLB_CLK_KHZ)

`endif

// *** design/flb_pkg.sv ***
// Types shared by the flash LED register bank modules.
// Assumes the constants header sits beside it.
`include "flb_params.svh"

package flb_pkg;

  typedef enum logic [1:0] {
    FLB_MODE_OFF = 2'h0,
    FLB_MODE_VIDEO = 2'h1,
    FLB_MODE_FLASH = 2'h2,
    FLB_MODE_VSRC = 2'h3
  } flb_mode_t;

  typedef enum logic [3:0] {
    FLB_IDLE = 4'h0,
    FLB_ADDR = 4'h1,
    FLB_ADDR_ACK = 4'h2,
    FLB_PTR = 4'h3,
    FLB_PTR_ACK = 4'h4,
    FLB_WDATA = 4'h5,
    FLB_WACK = 4'h6,
    FLB_RDATA = 4'h7,
    FLB_RACK = 4'h8
  } flb_state_t;

  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } flb_bus_ev_t;

  typedef struct packed {
    flb_mode_t mode;
    logic [8:0] video_ch13_ma;
    logic [8:0] video_ch2_ma;
    logic [10:0] flash_ch2_ma;
    logic leds_off;
    logic volt_reg;
    logic [3:0] vout_code;
  } flb_drive_t;

endpackage

// *** design/flb_register_bank.sv ***
// Host register bank of a flash and video LED driver, reached as a serial bus slave.
// Assumes pins synchronous to clk; the master never stretches or drives SDA during our ack.
// Contract
// (RQ1) Address byte first after start, checked first
// (RQ2) Pointer byte; low three bits pick register
// (RQ3) Soft reset bit restores all register defaults
// (RQ4) Channel 1/3 video current 25 mA steps
// (RQ5) Channel 2 video current 25 mA steps
// (RQ6) Channel 2 codes 6,7 boost under tx mask
// (RQ7) Both video codes zero: LEDs off, voltage mode
// (RQ8) Both flash codes zero: voltage regulation mode
// (RQ9) Mode field: off, video, flash, voltage source
// (RQ10) Video mode times out unless mode rewritten
// (RQ11) Mode write mirrored into register two
// (RQ12) Channel 2 flash current 25 mA per code
// (RQ13) Answer only fixed seven-bit address
// (RQ14) Unimplemented pointer reads return zero
// (RQ15) Ack every byte; commit after ack
// (RQ16) Hardware reset pin restores defaults, shutdown
`timescale 1ns/1ps
`default_nettype none
`include "flb_params.svh"

module flb_register_bank #(
  parameter int unsigned SAFETY_CYCLES = `FLB_SAFETY_CYCLES,
  parameter logic [6:0] DEV_ADDR = `FLB_I2C_ADDR
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hardware_reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic tx_mask,
  input wire logic [4:0] flash_current_ch13,
  input wire logic [3:0] output_voltage_setting,
  output var flb_pkg::flb_drive_t drive
);

  logic int_rst;
  flb_pkg::flb_bus_ev_t ev;
  flb_pkg::flb_state_t state_reg, state_next;
  logic [3:0] bitcnt_reg, bitcnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] ptr_reg, ptr_next;
  logic rw_reg, rw_next;
  logic nack_reg, nack_next;
  logic wr_stb;
  logic [7:0] video_reg, video_next;
  flb_pkg::flb_mode_t mode_reg, mode_next;
  logic [5:0] fc2_reg, fc2_next;
  flb_pkg::flb_drive_t drive_next;
  logic addr_hit, soft_rst, mode_write, tmr_expired;
  logic [7:0] rd_data;
  logic [2:0] video_current_ch13, video_current_ch2;
  logic [5:0] flash_current_ch2;
  logic video_zero, flash_zero, byte_done;

  assign int_rst = ~rst_n | ~hardware_reset_n; // see (RQ16)

  flb_bus_edges u_edges (
    .clk(clk),
    .rst(int_rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev(ev)
  );

  assign addr_hit = (shift_reg[7:1] == DEV_ADDR); // see (RQ13)
  assign byte_done = ev.scl_fall && (bitcnt_reg == 4'h8);

  // Bits are counted on SCL rises so the fall right after a start is not a bit
  always_comb begin
    state_next = state_reg;
    bitcnt_next = bitcnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    nack_next = nack_reg;
    wr_stb = 1'b0;
    if (ev.stop) begin
      state_next = flb_pkg::FLB_IDLE;
    end else if (ev.start) begin
      state_next = flb_pkg::FLB_ADDR; // see (RQ1)
      bitcnt_next = 4'h0;
    end else begin
      case (state_reg)
        flb_pkg::FLB_ADDR, flb_pkg::FLB_PTR, flb_pkg::FLB_WDATA: begin
          if (ev.scl_rise) begin
            shift_next = {shift_reg[6:0], sda_in};
            bitcnt_next = bitcnt_reg + 4'h1;
          end else if (byte_done) begin
            bitcnt_next = 4'h0;
            case (state_reg)
              flb_pkg::FLB_ADDR: begin
                state_next = addr_hit ? flb_pkg::FLB_ADDR_ACK : flb_pkg::FLB_IDLE; // see (RQ1)
                rw_next = shift_reg[0];
              end
              flb_pkg::FLB_PTR: begin
                state_next = flb_pkg::FLB_PTR_ACK;
                ptr_next = shift_reg[2:0]; // see (RQ2)
              end
              default: begin
                state_next = flb_pkg::FLB_WACK;
              end
            endcase
          end
        end
        flb_pkg::FLB_ADDR_ACK: begin
          if (ev.scl_fall) begin
            state_next = rw_reg ? flb_pkg::FLB_RDATA : flb_pkg::FLB_PTR;
            shift_next = rd_data;
          end
        end
        flb_pkg::FLB_PTR_ACK: begin
          if (ev.scl_fall) begin
            state_next = flb_pkg::FLB_WDATA;
          end
        end
        flb_pkg::FLB_WACK: begin
          if (ev.scl_fall) begin
            wr_stb = 1'b1; // see (RQ15)
            ptr_next = ptr_reg + 3'h1;
            state_next = flb_pkg::FLB_WDATA;
          end
        end
        flb_pkg::FLB_RDATA: begin
          if (ev.scl_rise) begin
            bitcnt_next = bitcnt_reg + 4'h1;
          end else if (byte_done) begin
            bitcnt_next = 4'h0;
            ptr_next = ptr_reg + 3'h1;
            state_next = flb_pkg::FLB_RACK;
          end else if (ev.scl_fall) begin
            shift_next = {shift_reg[6:0], 1'b0};
          end
        end
        flb_pkg::FLB_RACK: begin
          if (ev.scl_rise) begin
            nack_next = sda_in;
          end else if (ev.scl_fall) begin
            state_next = nack_reg ? flb_pkg::FLB_IDLE : flb_pkg::FLB_RDATA;
            shift_next = rd_data;
          end
        end
        default: begin
          state_next = flb_pkg::FLB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (int_rst) begin
      state_reg <= flb_pkg::FLB_IDLE; // see (RQ16)
      bitcnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 3'h0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      bitcnt_reg <= bitcnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      nack_reg <= nack_next;
    end
  end

  // Open drain: only ever pull low, during acks and zero data bits
  assign sda_out = 1'b0;
  assign sda_oe = (state_reg == flb_pkg::FLB_ADDR_ACK) || (state_reg == flb_pkg::FLB_PTR_ACK)
    || (state_reg == flb_pkg::FLB_WACK) // see (RQ15)
    || ((state_reg == flb_pkg::FLB_RDATA) && !shift_reg[7]);

  // Register two holds only the mirrored mode field here
  assign rd_data = (ptr_reg == `FLB_REG_VIDEO) ? video_reg
    : (ptr_reg == `FLB_REG_MODE) ? {mode_reg, fc2_reg}
    : (ptr_reg == `FLB_REG_MODE_COPY) ? {mode_reg, 6'h00}
    : 8'h00; // see (RQ14)

  assign soft_rst = wr_stb && (ptr_reg == `FLB_REG_VIDEO) && shift_reg[`FLB_SOFT_RESET_BIT]; // see (RQ3)
  assign mode_write = wr_stb && ((ptr_reg == `FLB_REG_MODE) || (ptr_reg == `FLB_REG_MODE_COPY));

  // Reset bit is self clearing, so it always reads back zero
  assign video_next = soft_rst ? `FLB_RST_VIDEO
    : (wr_stb && ptr_reg == `FLB_REG_VIDEO) ? {1'b0, shift_reg[6:0]} : video_reg;
  // One mode register serves both copies, so they can never disagree
  assign mode_next = soft_rst ? flb_pkg::flb_mode_t'(`FLB_RST_MODE)
    : mode_write ? flb_pkg::flb_mode_t'(shift_reg[`FLB_MODE_MSB:`FLB_MODE_LSB]) // see (RQ11)
    : tmr_expired ? flb_pkg::FLB_MODE_OFF : mode_reg; // see (RQ10)
  assign fc2_next = soft_rst ? `FLB_RST_FLASH2
    : (wr_stb && ptr_reg == `FLB_REG_MODE) ? shift_reg[`FLB_FC2_MSB:`FLB_FC2_LSB] : fc2_reg;

  always_ff @(posedge clk) begin
    if (int_rst) begin
      video_reg <= `FLB_RST_VIDEO; // see (RQ16)
      mode_reg <= flb_pkg::flb_mode_t'(`FLB_RST_MODE);
      fc2_reg <= `FLB_RST_FLASH2;
    end else begin
      video_reg <= video_next;
      mode_reg <= mode_next;
      fc2_reg <= fc2_next;
    end
  end

  flb_safety_timer #(
    .CYCLES(SAFETY_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst(int_rst),
    .run(mode_reg == flb_pkg::FLB_MODE_VIDEO), // see (RQ10)
    .restart(mode_write),
    .expired(tmr_expired)
  );

  assign video_current_ch13 = video_reg[`FLB_CH13_MSB:`FLB_CH13_LSB];
  assign video_current_ch2 = video_reg[`FLB_CH2_MSB:`FLB_CH2_LSB];
  assign flash_current_ch2 = fc2_reg;
  assign video_zero = (video_current_ch13 == 3'h0) && (video_current_ch2 == 3'h0);
  assign flash_zero = (flash_current_ch13 == 5'h00) && (flash_current_ch2 == 6'h00);

  assign drive_next.mode = mode_reg; // see (RQ9)
  assign drive_next.video_ch13_ma = 9'(11'(video_current_ch13) * `FLB_STEP_MA); // see (RQ4)
  assign drive_next.video_ch2_ma =
    (tx_mask && video_current_ch2 == `FLB_BOOST_HI_CODE) ? `FLB_BOOST_HI_MA // see (RQ6)
    : (tx_mask && video_current_ch2 == `FLB_BOOST_LO_CODE) ? `FLB_BOOST_LO_MA
    : 9'(11'(video_current_ch2) * `FLB_STEP_MA); // see (RQ5)
  assign drive_next.flash_ch2_ma = 11'(flash_current_ch2) * `FLB_STEP_MA; // see (RQ12)
  assign drive_next.leds_off = (mode_reg == flb_pkg::FLB_MODE_OFF)
    || (mode_reg == flb_pkg::FLB_MODE_VSRC)
    || ((mode_reg == flb_pkg::FLB_MODE_VIDEO) && video_zero) // see (RQ7)
    || ((mode_reg == flb_pkg::FLB_MODE_FLASH) && flash_zero); // see (RQ8)
  assign drive_next.volt_reg = (mode_reg == flb_pkg::FLB_MODE_VSRC)
    || ((mode_reg == flb_pkg::FLB_MODE_VIDEO) && video_zero) // see (RQ7)
    || ((mode_reg == flb_pkg::FLB_MODE_FLASH) && flash_zero); // see (RQ8)
  assign drive_next.vout_code = output_voltage_setting;

  always_ff @(posedge clk) begin
    if (int_rst) begin
      drive <= '0;
    end else begin
      drive <= drive_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (int_rst);

  addr_first_a: assert property ((state_reg == flb_pkg::FLB_ADDR) |-> !sda_oe) // see (RQ1)
    else $error("slave drove SDA during address byte");
  ptr_select_a: assert property ((state_reg == flb_pkg::FLB_PTR && byte_done && !ev.start
    && !ev.stop) |=> (ptr_reg == $past(shift_reg[2:0]))) // see (RQ2)
    else $error("pointer not taken from low bits");
  soft_reset_a: assert property (soft_rst |=> (video_reg == `FLB_RST_VIDEO) // see (RQ3)
    && (fc2_reg == `FLB_RST_FLASH2) && (mode_reg == flb_pkg::FLB_MODE_OFF))
    else $error("soft reset did not restore defaults");
  boost_hi_a: assert property ((video_current_ch2 == `FLB_BOOST_HI_CODE && tx_mask) // see (RQ6)
    |=> (drive.video_ch2_ma == `FLB_BOOST_HI_MA))
    else $error("channel 2 boost level wrong");
  video_volt_a: assert property ((mode_reg == flb_pkg::FLB_MODE_VIDEO && video_zero) // see (RQ7)
    |=> (drive.volt_reg && drive.leds_off))
    else $error("zero video codes not in voltage mode");
  mode_mirror_a: assert property ((wr_stb && ptr_reg == `FLB_REG_MODE) // see (RQ11)
    |=> (mode_reg == $past(shift_reg[7:6])) && (fc2_reg == $past(shift_reg[5:0])))
    else $error("register one write not committed");
  timeout_off_a: assert property ((tmr_expired && !mode_write && !soft_rst) // see (RQ10)
    |=> (mode_reg == flb_pkg::FLB_MODE_OFF))
    else $error("safety timeout did not shut down");
  wrong_addr_a: assert property ((state_reg == flb_pkg::FLB_ADDR && byte_done && !addr_hit
    && !ev.start && !ev.stop) |=> (state_reg == flb_pkg::FLB_IDLE) [*2]) // see (RQ13)
    else $error("foreign address acknowledged");
  unmapped_a: assert property ((ptr_reg > `FLB_REG_MODE_COPY) |-> (rd_data == 8'h00)) // see (RQ14)
    else $error("unmapped pointer read nonzero");
  ack_hold_a: assert property ((state_reg == flb_pkg::FLB_WACK && !ev.scl_fall && !ev.start
    && !ev.stop) |=> sda_oe) // see (RQ15)
    else $error("ack released early");
  hw_reset_a: assert property (@(posedge clk) disable iff (!rst_n) // see (RQ16)
    (!hardware_reset_n) |=> (mode_reg == flb_pkg::FLB_MODE_OFF)
    && (state_reg == flb_pkg::FLB_IDLE) && (video_reg == `FLB_RST_VIDEO))
    else $error("hardware reset did not restore defaults");
  boost_lo_a: assert property ((video_current_ch2 == `FLB_BOOST_LO_CODE && tx_mask) // see (RQ6)
    |=> (drive.video_ch2_ma == `FLB_BOOST_LO_MA))
    else $error("channel 2 low boost level wrong");
  ch13_top_a: assert property ((video_current_ch13 == 3'h7) // see (RQ4)
    |=> (drive.video_ch13_ma == 9'h0AF))
    else $error("channel 1/3 top video current wrong");
  ch2_top_a: assert property ((video_current_ch2 == 3'h7 && !tx_mask) // see (RQ5)
    |=> (drive.video_ch2_ma == 9'h0AF))
    else $error("channel 2 top video current wrong");
  flash_volt_a: assert property ((mode_reg == flb_pkg::FLB_MODE_FLASH && flash_zero) // see (RQ8)
    |=> (drive.volt_reg && drive.leds_off))
    else $error("zero flash codes not in voltage mode");
  vsrc_mode_a: assert property ((mode_reg == flb_pkg::FLB_MODE_VSRC) // see (RQ9)
    |=> (drive.mode == flb_pkg::FLB_MODE_VSRC) && drive.volt_reg && drive.leds_off)
    else $error("voltage source mode not driven");
  flash_default_a: assert property ((fc2_reg == `FLB_RST_FLASH2) // see (RQ12)
    |=> (drive.flash_ch2_ma == 11'h190))
    else $error("default flash current wrong");

endmodule // flb_register_bank

`default_nettype wire

// *** design/flb_safety_timer.sv ***
// Video light safety timer: pulses for one clock after every CYCLES clocks left running.
// Assumes restart comes from every write of the mode field.
`timescale 1ns/1ps
`default_nettype none

module flb_safety_timer #(
  parameter int unsigned CYCLES = 32'd650000000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic restart,
  output logic expired
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  generate
    if (CYCLES < 2) begin : g_bad
      $error("flb_safety_timer: CYCLES must be at least 2");
    end
  endgenerate

  logic [CW-1:0] cnt_reg;
  logic hit;

  assign hit = (cnt_reg == CW'(CYCLES - 1));

  always_ff @(posedge clk) begin
    if (rst || restart || !run) begin
      cnt_reg <= '0;
      expired <= 1'b0;
    end else begin
      cnt_reg <= hit ? '0 : cnt_reg + CW'(1);
      expired <= hit;
    end
  end

endmodule // flb_safety_timer

`default_nettype wire

// *** sim/flb_i2c_master.sv ***
// Behavioural serial bus master: drives the clock and pulls the data line low.
// Assumes the bench resolves the wired-and data line and feeds it back here.
`timescale 1ns/1ps
`default_nettype none

module flb_i2c_master (
  input wire logic clk,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Four clocks a phase stays above the two-sample minimum of the slave
  task automatic half();
    repeat (4) @(posedge clk);
  endtask

  // Also serves as repeated start: data released while the clock is low
  task automatic start();
    sda_low <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b1;
    half();
    scl <= 1'b0;
    half();
  endtask

  task automatic stop();
    sda_low <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b0;
    half();
  endtask

  // Eight bits MSB first, then the ninth bit; released bits read back the wire
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic ack);
    logic [8:0] b;
    b = {d, last};
    for (int i = 8; i >= 0; i--) begin
      sda_low <= ~b[i];
      half();
      scl <= 1'b1;
      half();
      if (i > 0) begin
        q[i-1] = sda;
      end else begin
        ack = sda;
      end
      scl <= 1'b0;
      half();
    end
  endtask
endmodule // flb_i2c_master

`default_nettype wire

// *** sim/tb_flb_register_bank.sv ***
// Self-checking bench: register model in integers, compared at every result.
// Assumes the master model and a pulled-up data line built here.
`timescale 1ns/1ps
`default_nettype none

module tb_flb_register_bank;
  logic clk, rst_n, hardware_reset_n, tx_mask, ack;
  logic [4:0] fl13;
  logic [3:0] vset;
  logic [7:0] q, d0, d1;
  wire logic scl, sda_low, sda_oe, sda_val;
  wire logic sda;
  flb_pkg::flb_drive_t drive;
  int err_count, tests_run, seed, r0, f2, md;

  // Pull-up: the line is high unless someone pulls it low
  assign sda = !sda_low && !(sda_oe && !sda_val);

  flb_i2c_master i_m (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));

  // Short safety count keeps the timeout scenario brief
  flb_register_bank #(.SAFETY_CYCLES(2000)) i_dut (.clk(clk), .rst_n(rst_n),
    .hardware_reset_n(hardware_reset_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_val),
    .sda_oe(sda_oe), .tx_mask(tx_mask), .flash_current_ch13(fl13),
    .output_voltage_setting(vset), .drive(drive));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [36:0] exp_drive();
    int c13, c2, z, ch2;
    c13 = (r0 >> 3) & 7;
    c2 = r0 & 7;
    ch2 = (tx_mask && c2 == 6) ? 225 : (tx_mask && c2 == 7) ? 325 : c2 * 25;
    z = (md == 3) || (md == 1 && (r0 & 63) == 0) || (md == 2 && fl13 == 0 && f2 == 0);
    return {2'(md), 9'(c13 * 25), 9'(ch2), 11'(f2 * 25), 1'(md == 0 || z), 1'(z), vset};
  endfunction

  task automatic defaults();
    r0 = 8'h0A;
    f2 = 16;
    md = 0;
  endtask

  task automatic mw(input int p, input logic [7:0] d);
    case (p & 7)
      0: begin
        if (d[7]) begin
          defaults();
        end else begin
          r0 = d;
        end
      end
      1: begin
        md = d[7:6];
        f2 = d[5:0];
      end
      2: md = d[7:6];
      default: ;
    endcase
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] b, input int n);
    i_m.start();
    i_m.xfer(8'h66, 1'b1, q, ack);
    chk(37'(ack), 37'h0);
    i_m.xfer(p, 1'b1, q, ack);
    chk(37'(ack), 37'h0);
    i_m.xfer(a, 1'b1, q, ack);
    chk(37'(ack), 37'h0);
    mw(p, a);
    if (n > 1) begin
      i_m.xfer(b, 1'b1, q, ack);
      chk(37'(ack), 37'h0);
      mw(p + 1, b);
    end
    i_m.stop();
  endtask

  task automatic rd(input int p);
    logic [7:0] e;
    e = (p == 0) ? 8'(r0) : (p == 1) ? 8'((md << 6) | f2) : (p == 2) ? 8'(md << 6) : 8'h00;
    i_m.start();
    i_m.xfer(8'h66, 1'b1, q, ack);
    i_m.xfer(8'(p), 1'b1, q, ack);
    i_m.start();
    i_m.xfer(8'h67, 1'b1, q, ack);
    chk(37'(ack), 37'h0);
    i_m.xfer(8'hFF, 1'b1, q, ack);
    i_m.stop();
    chk(37'(q), 37'(e));
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    wrap_up();
  end

  initial begin
    seed = 32'hba20;
    err_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    hardware_reset_n = 1'b1;
    tx_mask = 1'b0;
    fl13 = 5'h00;
    vset = 4'h0;
    defaults();
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(drive, exp_drive());
    for (int p = 0; p < 8; p++) begin
      rd(p);
    end
    $display("test reset values done");
    // Every mode, both boost codes with and without mask, then all-zero codes
    for (int i = 0; i < 8; i++) begin
      d0 = 8'($random(seed)) & 8'h7F;
      d1 = 8'($random(seed));
      d1[7:6] = i[1:0];
      d0[2:0] = {2'h3, i[0]};
      if (i > 3) begin
        d0[5:0] = 6'h00;
        d1[5:0] = 6'h00;
      end
      tx_mask <= i[1];
      fl13 <= (i == 6) ? 5'h00 : 5'($random(seed));
      vset <= 4'($random(seed));
      wr(8'h00, d0, d1, 2);
      chk(drive, exp_drive());
      rd(i % 3);
    end
    $display("test field decode done");
    i_m.start();
    i_m.xfer(8'h68, 1'b1, q, ack);
    chk(37'(ack), 37'h1);
    i_m.xfer(8'h00, 1'b1, q, ack);
    i_m.xfer(8'h80, 1'b1, q, ack);
    i_m.start();
    i_m.xfer(8'h00, 1'b1, q, ack);
    chk(37'(ack), 37'h1);
    i_m.stop();
    chk(drive, exp_drive());
    $display("test foreign address done");
    wr(8'h00, 8'h80, 8'h00, 1);
    chk(drive, exp_drive());
    rd(0);
    rd(1);
    $display("test soft reset done");
    // The rewrite must land inside the first safety window, or the restart goes untested
    wr(8'h01, 8'h45, 8'h00, 1);
    repeat (1400) @(posedge clk);
    chk(drive, exp_drive());
    wr(8'h02, 8'h40, 8'h00, 1);
    repeat (1900) @(posedge clk);
    chk(drive, exp_drive());
    repeat (200) @(posedge clk);
    md = 0;
    chk(drive, exp_drive());
    $display("test safety timeout done");
    wr(8'h00, 8'h3F, 8'h00, 1);
    hardware_reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    hardware_reset_n <= 1'b1;
    defaults();
    repeat (2) @(posedge clk);
    chk(drive, exp_drive());
    rd(0);
    $display("test hardware reset done");
    wrap_up();
  end
endmodule // tb_flb_register_bank

`default_nettype wire
